// [rtl/lpc_pkg.sv]
// Purpose: Constants for the lamp and transceiver control register bank
// Assumes: 16-bit registers held in the low half of 32-bit AXI4-Lite words, except ABIL, which uses both halves
// Notes: Printed offsets are register indices; byte address is four times the index modulo 256, so ABIL sits at 0x00
package lpc_pkg;
    localparam int LPC_CLK_HZ = 125_000_000;
    localparam int LPC_ADDR_W = 8;
    // Register indices and byte addresses
    localparam logic [7:0] LPC_IDX_LAMP = 8'h18;
    localparam logic [7:0] LPC_IDX_PHY = 8'h19;
    localparam logic [7:0] LPC_IDX_ABIL = 8'h40;
    localparam logic [7:0] LPC_ADDR_LAMP = 8'(LPC_IDX_LAMP * 4);
    localparam logic [7:0] LPC_ADDR_PHY = 8'(LPC_IDX_PHY * 4);
    localparam logic [7:0] LPC_ADDR_ABIL = 8'(LPC_IDX_ABIL * 4);
    // Lamp control fields
    localparam int LPC_RATE_HI = 10;
    localparam int LPC_RATE_LO = 9;
    localparam int LPC_POL_BIT = 7;
    localparam int LPC_FORCE_BIT = 4;
    localparam int LPC_ONOFF_BIT = 1;
    localparam logic [1:0] LPC_RATE_RST = 2'h2;
    // Transceiver control fields
    localparam int LPC_AMDIX_BIT = 15;
    localparam int LPC_XOVER_BIT = 14;
    localparam int LPC_PRX_BIT = 13;
    localparam int LPC_PTX_BIT = 12;
    localparam int LPC_BYP_BIT = 7;
    localparam int LPC_CFG_BIT = 5;
    localparam int LPC_ADR_HI = 4;
    // Ability word pause fields
    localparam int LPC_PAUSE_BIT = 10;
    localparam int LPC_ASYM_BIT = 11;
    // Blink durations in ms and counter width
    localparam int LPC_T50_MS = 50;
    localparam int LPC_T100_MS = 100;
    localparam int LPC_T200_MS = 200;
    localparam int LPC_T500_MS = 500;
    localparam int LPC_CNT_W = 27;
    localparam logic [1:0] LPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LPC_RESP_SLVERR = 2'h2;
endpackage : lpc_pkg

// [rtl/lpc_sync2.sv]
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Inputs are static or slow relative to aclk
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module lpc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : lpc_sync2

// [rtl/lpc_pause_res.sv]
// Purpose: Pause resolution from local and partner ability bits
// Assumes: Full-duplex indication comes from the negotiation engine
// Notes: Combinational; the caller registers the result
`timescale 1ns/10ps
module lpc_pause_res
    import lpc_pkg::*;
(
    // Ability words
    input wire logic [15:0] local_ability_advert,
    input wire logic [15:0] partner_ability_word,
    input wire logic full_duplex,
    // Resolved enables
    output logic pause_rx,
    output logic pause_tx
);
    logic lp;
    logic la;
    logic pp;
    logic pa;

    assign lp = local_ability_advert[LPC_PAUSE_BIT];
    assign la = local_ability_advert[LPC_ASYM_BIT];
    assign pp = partner_ability_word[LPC_PAUSE_BIT];
    assign pa = partner_ability_word[LPC_ASYM_BIT];

    // Symmetric pause, or asymmetric one-way cases, gated by full duplex
    always_comb begin
        pause_rx = full_duplex && ((lp && pp) || (lp && la && !pp && pa));
        pause_tx = full_duplex && ((lp && pp) || (!lp && la && pp && pa));
    end
endmodule : lpc_pause_res

// [rtl/lpc_regs.sv]
// Purpose: Status lamp control and transceiver control register bank
// Assumes: AXI4-Lite slave on aclk; straps and link status arrive as pins
// Notes: Reserved bits read as zero; unmapped addresses answer SLVERR
`timescale 1ns/10ps
module lpc_regs
    import lpc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [LPC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [LPC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Straps and link state pins
    input wire logic strap_lamp_pol,
    input wire logic strap_auto_xover,
    input wire logic strap_lamp_meaning,
    input wire logic [4:0] strap_phy_addr,
    input wire logic link_up,
    input wire logic txrx_activity,
    input wire logic neg_full_duplex,
    // Negotiation ability words
    input wire logic [15:0] local_ability_advert,
    input wire logic [15:0] partner_ability_word,
    // Outputs
    output logic status_lamp_out,
    output logic automatic_pair_crossover,
    output logic crossed_pair_mode,
    output logic pause_rx_en,
    output logic pause_tx_en
);
    localparam logic [LPC_CNT_W-1:0] CYC_PER_MS = LPC_CNT_W'(LPC_CLK_HZ / 1000);

    typedef enum logic [3:0] {
        LPC_RST0 = 4'b0001,
        LPC_RST1 = 4'b0010,
        LPC_LOAD = 4'b0100,
        LPC_RUN = 4'b1000
    } lpc_state_t;

    function automatic logic [LPC_CNT_W-1:0] lpc_dur(input logic [1:0] rate);
        case (rate)
            2'h0: lpc_dur = LPC_CNT_W'(LPC_T50_MS) * CYC_PER_MS;
            2'h1: lpc_dur = LPC_CNT_W'(LPC_T100_MS) * CYC_PER_MS;
            2'h2: lpc_dur = LPC_CNT_W'(LPC_T200_MS) * CYC_PER_MS;
            default: lpc_dur = LPC_CNT_W'(LPC_T500_MS) * CYC_PER_MS;
        endcase
    endfunction : lpc_dur

    function automatic logic [15:0] lpc_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        lpc_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : lpc_merge

    // Synchronised straps and link pins; full duplex passes straight through
    logic [9:0] sync_in;
    logic [4:0] s_addr;
    logic s_pol, s_amdix, s_cfg, s_link, s_act, s_fdx;

    lpc_sync2 #(.W(10)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({strap_lamp_pol, strap_auto_xover, strap_lamp_meaning, strap_phy_addr,
              link_up, txrx_activity}),
        .dout(sync_in)
    );
    assign {s_pol, s_amdix, s_cfg, s_addr, s_link, s_act} = sync_in;
    assign s_fdx = neg_full_duplex;

    logic prx, ptx;

    lpc_pause_res u_pause (
        .local_ability_advert(local_ability_advert),
        .partner_ability_word(partner_ability_word),
        .full_duplex(s_fdx),
        .pause_rx(prx),
        .pause_tx(ptx)
    );

    // Control register fields
    logic [1:0] blink_rate;
    logic lamp_pol, lamp_force, lamp_onoff, pause_rx_st, pause_tx_st;
    logic amdix_en, xover, stretch_byp, lamp_meaning_select;
    logic [4:0] phy_addr;
    lpc_state_t state;

    // Strap capture: the synchroniser holds valid strap levels from the second edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= LPC_RST0;
        end else begin
            case (state)
                LPC_RST0: state <= LPC_RST1;
                LPC_RST1: state <= LPC_LOAD;
                LPC_LOAD: state <= LPC_RUN;
                LPC_RUN: state <= LPC_RUN;
                default: state <= LPC_RST0;
            endcase
        end
    end

    // AXI write channel
    logic aw_hold, w_hold, wr_go;
    logic [LPC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_hold;
    assign s_axi_wready = !w_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LPC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == LPC_ADDR_LAMP || aw_addr == LPC_ADDR_PHY) ?
                           LPC_RESP_OKAY : LPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic [15:0] lamp_word, phy_word, lamp_new, phy_new;

    assign lamp_new = lpc_merge(lamp_word, w_data, w_strb);
    assign phy_new = lpc_merge(phy_word, w_data, w_strb);

    // Lamp control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_rate <= LPC_RATE_RST;
            lamp_pol <= 1'b0;
            lamp_force <= 1'b0;
            lamp_onoff <= 1'b0;
        end else if (wr_go && aw_addr == LPC_ADDR_LAMP) begin
            blink_rate <= lamp_new[LPC_RATE_HI:LPC_RATE_LO];
            lamp_pol <= lamp_new[LPC_POL_BIT];
            lamp_force <= lamp_new[LPC_FORCE_BIT];
            lamp_onoff <= lamp_new[LPC_ONOFF_BIT];
        end else if (state == LPC_LOAD) begin
            lamp_pol <= s_pol;
        end
    end

    // Transceiver control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            amdix_en <= 1'b0;
            xover <= 1'b0;
            stretch_byp <= 1'b0;
            lamp_meaning_select <= 1'b1;
            phy_addr <= '0;
        end else if (wr_go && aw_addr == LPC_ADDR_PHY) begin
            amdix_en <= phy_new[LPC_AMDIX_BIT];
            xover <= phy_new[LPC_XOVER_BIT];
            stretch_byp <= phy_new[LPC_BYP_BIT];
            lamp_meaning_select <= phy_new[LPC_CFG_BIT];
        end else if (state == LPC_LOAD) begin
            amdix_en <= s_amdix;
            lamp_meaning_select <= s_cfg;
            phy_addr <= s_addr;
        end
    end

    // Pause resolution status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_rx_st <= 1'b0;
            pause_tx_st <= 1'b0;
        end else begin
            pause_rx_st <= prx;
            pause_tx_st <= ptx;
        end
    end

    always_comb begin
        lamp_word = '0;
        lamp_word[LPC_RATE_HI:LPC_RATE_LO] = blink_rate;
        lamp_word[LPC_POL_BIT] = lamp_pol;
        lamp_word[LPC_FORCE_BIT] = lamp_force;
        lamp_word[LPC_ONOFF_BIT] = lamp_onoff;
        phy_word = '0;
        phy_word[LPC_AMDIX_BIT] = amdix_en;
        phy_word[LPC_XOVER_BIT] = xover;
        phy_word[LPC_PRX_BIT] = pause_rx_st;
        phy_word[LPC_PTX_BIT] = pause_tx_st;
        phy_word[LPC_BYP_BIT] = stretch_byp;
        phy_word[LPC_CFG_BIT] = lamp_meaning_select;
        phy_word[LPC_ADR_HI:0] = phy_addr;
    end

    // AXI read channel, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= LPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= LPC_RESP_OKAY;
            case (s_axi_araddr)
                LPC_ADDR_LAMP: s_axi_rdata <= {16'h0000, lamp_word};
                LPC_ADDR_PHY: s_axi_rdata <= {16'h0000, phy_word};
                LPC_ADDR_ABIL: s_axi_rdata <= {partner_ability_word, local_ability_advert};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= LPC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Blink timebase, restarted on rate change
    logic [LPC_CNT_W-1:0] blink_cnt, stretch_cnt;
    logic [1:0] rate_seen;
    logic blink_phase, act_shown, lamp_on;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt <= '0;
            rate_seen <= LPC_RATE_RST;
            blink_phase <= 1'b0;
        end else if (rate_seen != blink_rate) begin
            rate_seen <= blink_rate;
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (blink_cnt >= lpc_dur(blink_rate) - 1'b1) begin
            blink_cnt <= '0;
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // Activity stretch: hold for one blink duration after last activity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stretch_cnt <= '0;
        end else if (s_act) begin
            stretch_cnt <= lpc_dur(blink_rate);
        end else if (stretch_cnt != '0) begin
            stretch_cnt <= stretch_cnt - 1'b1;
        end
    end

    assign act_shown = stretch_byp ? s_act : (s_act || stretch_cnt != '0);

    always_comb begin
        if (lamp_force) begin
            lamp_on = lamp_onoff;
        end else if (lamp_meaning_select) begin
            lamp_on = s_link;
        end else if (stretch_byp) begin
            lamp_on = s_link && !act_shown;
        end else begin
            lamp_on = s_link && !(act_shown && blink_phase);
        end
    end

    // Registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_lamp_out <= 1'b1;
            automatic_pair_crossover <= 1'b0;
            crossed_pair_mode <= 1'b0;
            pause_rx_en <= 1'b0;
            pause_tx_en <= 1'b0;
        end else begin
            status_lamp_out <= lamp_pol ? lamp_on : !lamp_on;
            automatic_pair_crossover <= amdix_en;
            crossed_pair_mode <= xover;
            pause_rx_en <= pause_rx_st;
            pause_tx_en <= pause_tx_st;
        end
    end

    // Checks
    AST_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
        lamp_force |=> status_lamp_out == ($past(lamp_pol) ~^ $past(lamp_onoff)))
        else $error("forced lamp level wrong");
    AST_POL: assert property (@(posedge aclk) disable iff (!aresetn)
        state == LPC_RUN && lamp_force && lamp_onoff |=> status_lamp_out == $past(lamp_pol))
        else $error("lamp polarity wrong");
    AST_STRAP: assert property (@(posedge aclk) disable iff (!aresetn)
        state == LPC_LOAD && !(wr_go && aw_addr == LPC_ADDR_LAMP) |=> lamp_pol == $past(s_pol))
        else $error("strap polarity not loaded");
    AST_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(blink_rate) |=> blink_cnt == '0)
        else $error("blink count not restarted");
    AST_XOVER: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 crossed_pair_mode == $past(xover))
        else $error("crossover output mismatch");
    AST_AMDIX: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 automatic_pair_crossover == $past(amdix_en))
        else $error("auto crossover output mismatch");
    AST_PAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        !s_fdx |=> !pause_rx_st && !pause_tx_st)
        else $error("pause without full duplex");
    AST_PRX: assert property (@(posedge aclk) disable iff (!aresetn)
        s_fdx && local_ability_advert[LPC_PAUSE_BIT] && partner_ability_word[LPC_PAUSE_BIT]
        |=> pause_rx_st)
        else $error("symmetric pause not resolved");
    AST_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
        !lamp_force && lamp_meaning_select && s_link && lamp_pol |=> status_lamp_out)
        else $error("link lamp not on");
    AST_BYP: assert property (@(posedge aclk) disable iff (!aresetn)
        stretch_byp && !lamp_force && !lamp_meaning_select && s_link && !s_act && lamp_pol
        |=> status_lamp_out)
        else $error("stretch not bypassed");
    AST_RST: assert property (@(posedge aclk) $rose(aresetn) |-> blink_rate == LPC_RATE_RST)
        else $error("blink rate reset wrong");
    COV_WRITE: cover property (@(posedge aclk) wr_go && aw_addr == LPC_ADDR_LAMP);
    COV_BLINK: cover property (@(posedge aclk) $rose(blink_phase));
    COV_PAUSE: cover property (@(posedge aclk) $rose(pause_rx_st));
    COV_FORCE: cover property (@(posedge aclk) lamp_force && $changed(status_lamp_out));
endmodule : lpc_regs

// [tb/lpc_link_model.sv]
// Purpose: Behavioural model of the negotiation engine and MAC activity feed
// Assumes: Driven from the bench through tasks; changes land just after a rising edge
// Notes: Ability words carry unrelated bits beside the pause pair so only bits 11:10 matter
`timescale 1ns/10ps
module lpc_link_model (
    // Clock
    input wire logic aclk,
    // Toward the register bank
    output logic [15:0] local_ability_advert,
    output logic [15:0] partner_ability_word,
    output logic neg_full_duplex,
    output logic link_up,
    output logic txrx_activity
);
    initial begin
        local_ability_advert = 16'h0000;
        partner_ability_word = 16'h0000;
        neg_full_duplex = 1'b0;
        link_up = 1'b0;
        txrx_activity = 1'b0;
    end

    // Pair order is {asym, pause}; the low bits stand for other advertised abilities
    task automatic set_abil(input logic [1:0] loc, input logic [1:0] par, input logic fd);
        @(posedge aclk);
        local_ability_advert <= {4'h0, loc, 10'h1e1};
        partner_ability_word <= {4'h0, par, 10'h0a1};
        neg_full_duplex <= fd;
    endtask : set_abil

    task automatic set_line(input logic lk, input logic act);
        @(posedge aclk);
        link_up <= lk;
        txrx_activity <= act;
    endtask : set_line
endmodule : lpc_link_model

// [tb/lamp_and_phy_control_regs_bench.sv]
// Purpose: Self-checking bench for the lamp and transceiver control register bank
// Assumes: Straps static from time zero; AXI4-Lite master samples handshakes at mid-cycle
// Notes: Blink durations are too long to run, so lamp checks use force and steady states
`timescale 1ns/10ps
module lamp_and_phy_control_regs_bench;
    import lpc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [15:0] loc_w, par_w;
    logic fd_w, link_w, act_w, lamp, axo, xpm, prx, ptx;
    logic erx, etx;
    int n_fail = 0;
    int check_count = 0;

    initial begin
        forever #4 aclk = ~aclk;
    end

    lpc_regs i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .strap_lamp_pol(1'b1), .strap_auto_xover(1'b1), .strap_lamp_meaning(1'b1),
        .strap_phy_addr(5'h05), .link_up(link_w), .txrx_activity(act_w),
        .neg_full_duplex(fd_w), .local_ability_advert(loc_w), .partner_ability_word(par_w),
        .status_lamp_out(lamp), .automatic_pair_crossover(axo), .crossed_pair_mode(xpm),
        .pause_rx_en(prx), .pause_tx_en(ptx));

    lpc_link_model i_link (.aclk(aclk), .local_ability_advert(loc_w),
        .partner_ability_word(par_w), .neg_full_duplex(fd_w), .link_up(link_w),
        .txrx_activity(act_w));

    task automatic stop_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Handshakes are judged at mid-cycle, then acted on by the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int n;
        logic got, aok, wok;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(negedge aclk);
            aok = awvalid && awready;
            wok = wvalid && wready;
            if (bvalid) begin
                resp = bresp;
                got = 1'b1;
            end
            @(posedge aclk);
            if (aok) awvalid <= 1'b0;
            if (wok) wvalid <= 1'b0;
            if (got) bready <= 1'b0;
        end
        if (!got) begin
            n_fail++;
            stop_test();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        logic got, aok;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && !got; n++) begin
            @(negedge aclk);
            aok = arvalid && arready;
            if (rvalid) begin
                v = rdata;
                resp = rresp;
                got = 1'b1;
            end
            @(posedge aclk);
            if (aok) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
        end
        if (!got) begin
            n_fail++;
            stop_test();
        end
    endtask : rd

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] resp;
        wr(a, v, resp);
        check(32'(resp), 32'(LPC_RESP_OKAY));
        cyc(4);
    endtask : wr_chk

    initial begin
        cyc(3);
        aresetn <= 1'b1;
        cyc(6);
        rd(LPC_ADDR_LAMP, d, r);
        check(d, 32'h0000_0480);
        check(32'(r), 32'(LPC_RESP_OKAY));
        rd(LPC_ADDR_PHY, d, r);
        check(d, 32'h0000_8025);
        check(32'({axo, xpm}), 32'h0000_0002);
        // Every pause pairing, with and without a full-duplex result
        for (int i = 0; i < 32; i++) begin
            i_link.set_abil({i[1], i[0]}, {i[3], i[2]}, i[4]);
            cyc(4);
            erx = i[4] & ((i[0] & i[2]) | (i[0] & i[1] & i[3] & !i[2]));
            etx = i[4] & ((i[0] & i[2]) | (i[1] & !i[0] & i[2] & i[3]));
            rd(LPC_ADDR_PHY, d, r);
            check(32'(d[13:12]), 32'({erx, etx}));
            check(32'({prx, ptx}), 32'({erx, etx}));
        end
        i_link.set_abil(2'b00, 2'b00, 1'b0);
        rd(8'h00, d, r);
        check(d, 32'h00a1_01e1);
        // All ones: reserved and read-only places keep their values
        wr_chk(LPC_ADDR_LAMP, 32'hffff_ffff);
        rd(LPC_ADDR_LAMP, d, r);
        check(d, 32'h0000_0692);
        check(32'(lamp), 32'h1);
        wr_chk(LPC_ADDR_PHY, 32'hffff_ffff);
        rd(LPC_ADDR_PHY, d, r);
        check(d, 32'h0000_c0a5);
        check(32'({axo, xpm}), 32'h0000_0003);
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0090);
        check(32'(lamp), 32'h0);
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0010);
        check(32'(lamp), 32'h1);
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0012);
        check(32'(lamp), 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr_chk(LPC_ADDR_LAMP, 32'(k) << 9);
            rd(LPC_ADDR_LAMP, d, r);
            check(d, 32'(k) << 9);
        end
        // Link-only meaning follows the link level
        wr_chk(LPC_ADDR_PHY, 32'h0000_0020);
        check(32'({axo, xpm}), 32'h0000_0000);
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0080);
        i_link.set_line(1'b1, 1'b0);
        cyc(6);
        check(32'(lamp), 32'h1);
        i_link.set_line(1'b0, 1'b1);
        cyc(6);
        check(32'(lamp), 32'h0);
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0000);
        i_link.set_line(1'b1, 1'b0);
        cyc(6);
        check(32'(lamp), 32'h0);
        // Bypassed stretching: lamp returns to link state right after activity
        wr_chk(LPC_ADDR_LAMP, 32'h0000_0080);
        wr_chk(LPC_ADDR_PHY, 32'h0000_0080);
        i_link.set_line(1'b1, 1'b1);
        cyc(6);
        check(32'(lamp), 32'h0);
        i_link.set_line(1'b1, 1'b0);
        cyc(6);
        check(32'(lamp), 32'h1);
        // Unmapped place answers with an error and no data
        rd(8'h08, d, r);
        check(d, 32'h0000_0000);
        check(32'(r), 32'(LPC_RESP_SLVERR));
        wr(8'h08, 32'hffff_ffff, r);
        check(32'(r), 32'(LPC_RESP_SLVERR));
        stop_test();
    end
endmodule : lamp_and_phy_control_regs_bench
